// >>> core/msq_sequencer.sv
/*
  Measurement instruction sequencer: configure, initiate, fetch, read,
  measure and configuration query, issued over APB, with hold-off of
  later commands while a measure, read or fetch awaits its acquisition.
  Assumes an acquisition engine that answers acq_start with one acq_done
  pulse unless aborted, and a formatter that renders the queued result
  word using its tag.
*/
// Chosen here: the placing of the registers and the APB register port.
// Contract
// - Measure configures, acquires, queues one result
// - Configure sets up but never starts acquisition
// - Read equals initiate then fetch
// - Acquired data kept for repeated fetches
// - Unexpected parameter ignored, command warning set
// - No valid data logs error -230
// - Fetch without data returns not-a-number
// - Omitted or default parameters take defaults
// - Configure and measure disable math, statistics, limits
// - Channel 1, non-peaks: enable, level, invoke auto-trigger
// - Configuration query reports last configure or measure
// - Reset, recall, function select leave configuration alone
// - Query before any configure: error, empty reply
// - Fetch derives only listed function pairs
// - Fetch without function uses last function
// - Fetch during measurement stalls later commands; here a fetch in the acq_done cycle is dropped
// - Measure during measurement aborts, restarts, stalls
// - Replies follow ASCII or real format
// - ASCII replies carry 1 to 15 digits
// - Read mid-measurement aborts, idles, restarts, stalls
`timescale 1ns/1ns
`include "msq_map.svh"

module msq_sequencer (
  // Clock, reset, clock enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Device clear request
  input wire logic dev_clear,
  // Acquisition engine
  output logic acq_start,
  output logic acq_abort,
  output msq_pkg::msq_acq_s acq_sel,
  input wire logic acq_done,
  input wire logic acq_ok,
  input wire logic [31:0] acq_value,
  // Measurement settings
  output logic math_en,
  output logic stats_en,
  output logic limit_en,
  output logic atrig_en,
  output logic atrig_level_set,
  output logic atrig_run
);

  // Function pairs that can be derived from one another
  function automatic logic can_derive(msq_pkg::msq_fn_e want, msq_pkg::msq_fn_e have);
    logic want_pk;
    logic have_pk;
    want_pk = (want == msq_pkg::FN_VMAX) || (want == msq_pkg::FN_VMIN) ||
              (want == msq_pkg::FN_PTP);
    have_pk = (have == msq_pkg::FN_VMAX) || (have == msq_pkg::FN_VMIN) ||
              (have == msq_pkg::FN_PTP);
    can_derive = (want == have) || (want_pk && have_pk) ||
                 (want == msq_pkg::FN_FREQ && have == msq_pkg::FN_PER) ||
                 (want == msq_pkg::FN_PER && have == msq_pkg::FN_FREQ);
  endfunction : can_derive

  // Peaks functions never use auto-trigger
  function automatic logic is_peaks(msq_pkg::msq_fn_e fn);
    is_peaks = (fn == msq_pkg::FN_VMAX) || (fn == msq_pkg::FN_VMIN) ||
               (fn == msq_pkg::FN_PTP);
  endfunction : is_peaks

  // State
  msq_pkg::msq_st_e st_q; // Sequencer state
  logic fin_q; // Fetch owed after completion
  msq_pkg::msq_fn_e pend_fn_q; // Function of the owed fetch
  msq_pkg::msq_fn_e last_fn_q; // Last used function
  logic [31:0] pexp_q; // Expected value staging
  logic [31:0] pres_q; // Resolution staging
  logic fmt_real_q; // Reply format, 1 = real
  logic [3:0] digits_q; // Resolution digits
  msq_pkg::msq_cfg_s cfg_q; // Configuration record
  logic [31:0] cexp_q; // Configured expected value
  logic [31:0] cres_q; // Configured resolution
  logic conf_valid_q; // Configured since power-on
  logic data_valid_q; // Stored acquisition valid
  msq_pkg::msq_fn_e data_fn_q; // Function stored data belongs to
  logic [31:0] data_q; // Stored acquisition
  logic [31:0] res_q; // Queued reply word
  msq_pkg::msq_tag_s tag_q; // Queued reply tag
  logic qvalid_q; // Reply waiting in queue
  logic warn_q; // Command warning, sticky
  logic err_q; // Error logged, sticky
  logic ovr_q; // Reply overwritten, sticky
  logic [15:0] err_code_q; // Last error code
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic atrig_pend_q; // Auto-trigger to invoke next cycle

  // Decoded command
  msq_pkg::msq_cmd_s cmd;
  msq_pkg::msq_ch_e cmd_ch; // Channel list after defaulting
  msq_pkg::msq_fn_e req_fn; // Fetch function after defaulting
  logic busy; // Hold-off of further commands
  logic wr_fire;
  logic rd_fire;
  logic exec;
  logic is_cfg; // Configure or measure
  logic do_atrig;
  logic imm_fetch;
  logic fetch_go;
  msq_pkg::msq_fn_e fetch_fn;
  logic fetch_ok;
  logic push;

  assign cmd = msq_pkg::msq_cmd_s'(pwdata[`MSQ_CMD_W-1:0]);
  assign busy = (st_q == msq_pkg::ST_HOLD) || (st_q == msq_pkg::ST_RESTART) || fin_q;
  assign wr_fire = ce && psel && penable && pready_q && pwrite;
  assign rd_fire = ce && psel && penable && pready_q && !pwrite;
  assign exec = wr_fire && (paddr == `MSQ_OFF_CMD);
  assign is_cfg = exec && (cmd.op == msq_pkg::OP_CONF || cmd.op == msq_pkg::OP_MEAS);
  // Omitted channel list takes the function's default
  assign cmd_ch = (cmd.ch != msq_pkg::CH_OMIT) ? cmd.ch :
                  (cmd.fn == msq_pkg::FN_RATIO) ? msq_pkg::CH_12 : msq_pkg::CH_1;
  assign do_atrig = is_cfg && !is_peaks(cmd.fn) && (cmd_ch != msq_pkg::CH_2);
  assign req_fn = (cmd.fn == msq_pkg::FN_NONE) ? last_fn_q : cmd.fn;
  assign imm_fetch = exec && (cmd.op == msq_pkg::OP_FETCH) && (st_q == msq_pkg::ST_IDLE);
  assign fetch_go = imm_fetch || fin_q;
  assign fetch_fn = imm_fetch ? req_fn : pend_fn_q;
  assign fetch_ok = data_valid_q && can_derive(fetch_fn, data_fn_q);
  assign push = fetch_go || (exec && cmd.op == msq_pkg::OP_CONFQ);

  // Read data for an address
  function automatic logic [31:0] rd_word(logic [7:0] a);
    rd_word = 32'h0000_0000;
    if (a == `MSQ_OFF_PEXP) begin
      rd_word = pexp_q;
    end else if (a == `MSQ_OFF_PRES) begin
      rd_word = pres_q;
    end else if (a == `MSQ_OFF_CTRL) begin
      rd_word[`MSQ_CTRL_MATH] = math_en;
      rd_word[`MSQ_CTRL_STATS] = stats_en;
      rd_word[`MSQ_CTRL_LIMIT] = limit_en;
      rd_word[`MSQ_CTRL_ATRIG] = atrig_en;
      rd_word[`MSQ_CTRL_FMT] = fmt_real_q;
      rd_word[`MSQ_CTRL_DIG_MSB:`MSQ_CTRL_DIG_LSB] = digits_q;
    end else if (a == `MSQ_OFF_STAT) begin
      rd_word[`MSQ_ST_BUSY] = busy;
      rd_word[`MSQ_ST_RUN] = (st_q != msq_pkg::ST_IDLE);
      rd_word[`MSQ_ST_DATA] = data_valid_q;
      rd_word[`MSQ_ST_QVALID] = qvalid_q;
      rd_word[`MSQ_ST_WARN] = warn_q;
      rd_word[`MSQ_ST_ERR] = err_q;
      rd_word[`MSQ_ST_OVR] = ovr_q;
      rd_word[`MSQ_ST_CONF] = conf_valid_q;
    end else if (a == `MSQ_OFF_ERR) begin
      rd_word[15:0] = err_code_q;
    end else if (a == `MSQ_OFF_CONF) begin
      rd_word[`MSQ_CFG_W-1:0] = cfg_q;
    end else if (a == `MSQ_OFF_CEXP) begin
      rd_word = cexp_q;
    end else if (a == `MSQ_OFF_CRES) begin
      rd_word = cres_q;
    end else if (a == `MSQ_OFF_RES) begin
      rd_word = res_q;
    end else if (a == `MSQ_OFF_TAG) begin
      rd_word[`MSQ_TAG_W-1:0] = tag_q;
    end
  endfunction : rd_word

  // Address is mapped
  function automatic logic mapped(logic [7:0] a);
    mapped = (a == `MSQ_OFF_CMD) || (a == `MSQ_OFF_PEXP) || (a == `MSQ_OFF_PRES) ||
             (a == `MSQ_OFF_CTRL) || (a == `MSQ_OFF_STAT) || (a == `MSQ_OFF_ERR) ||
             (a == `MSQ_OFF_CONF) || (a == `MSQ_OFF_CEXP) || (a == `MSQ_OFF_CRES) ||
             (a == `MSQ_OFF_RES) || (a == `MSQ_OFF_TAG);
  endfunction : mapped

  // APB answer: one wait state; a command write waits out the hold-off
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else if (ce) begin
      if (psel && penable && !pready_q) begin
        // Stall the next command until the pending one completes
        if (!(pwrite && paddr == `MSQ_OFF_CMD && busy)) begin
          pready_q <= 1'b1;
          prdata_q <= pwrite ? 32'h0000_0000 : rd_word(paddr);
          pslverr_q <= !mapped(paddr);
        end
      end else begin
        pready_q <= 1'b0;
        pslverr_q <= 1'b0;
      end
    end
  end

  // Parameter staging registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pexp_q <= 32'h0000_0000;
      pres_q <= 32'h0000_0000;
    end else if (wr_fire) begin
      if (paddr == `MSQ_OFF_PEXP) begin
        pexp_q <= pwdata;
      end else if (paddr == `MSQ_OFF_PRES) begin
        pres_q <= pwdata;
      end
    end
  end

  // Measurement settings; configure and measure override software
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      math_en <= 1'b0;
      stats_en <= 1'b0;
      limit_en <= 1'b0;
      atrig_en <= 1'b0;
      fmt_real_q <= 1'b0;
      digits_q <= `MSQ_DIG_RST;
    end else if (is_cfg) begin
      math_en <= 1'b0;
      stats_en <= 1'b0;
      limit_en <= 1'b0;
      atrig_en <= do_atrig ? 1'b1 : atrig_en;
    end else if (wr_fire && paddr == `MSQ_OFF_CTRL) begin
      math_en <= pwdata[`MSQ_CTRL_MATH];
      stats_en <= pwdata[`MSQ_CTRL_STATS];
      limit_en <= pwdata[`MSQ_CTRL_LIMIT];
      atrig_en <= pwdata[`MSQ_CTRL_ATRIG];
      fmt_real_q <= pwdata[`MSQ_CTRL_FMT];
      // Digits clamp into 1 to 15
      digits_q <= (pwdata[`MSQ_CTRL_DIG_MSB:`MSQ_CTRL_DIG_LSB] == 4'h0) ? 4'h1 :
                  pwdata[`MSQ_CTRL_DIG_MSB:`MSQ_CTRL_DIG_LSB];
    end
  end

  // Auto-trigger: enable and level first, invoke one cycle later
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      atrig_level_set <= 1'b0;
      atrig_run <= 1'b0;
      atrig_pend_q <= 1'b0;
    end else if (ce) begin
      atrig_level_set <= do_atrig;
      atrig_pend_q <= do_atrig;
      atrig_run <= atrig_pend_q;
    end
  end

  // Configuration record; only configure and measure touch it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_q <= '0;
      cexp_q <= 32'h0000_0000;
      cres_q <= 32'h0000_0000;
      conf_valid_q <= 1'b0;
    end else if (is_cfg) begin
      cfg_q.fn <= cmd.fn;
      cfg_q.ch <= cmd_ch;
      // Default keyword or omission; resolution defaults too when expected is omitted
      cfg_q.exp_def <= (cmd.exp != msq_pkg::P_VAL);
      cfg_q.res_def <= (cmd.res != msq_pkg::P_VAL) || (cmd.exp == msq_pkg::P_OMIT);
      cexp_q <= (cmd.exp == msq_pkg::P_VAL) ? pexp_q : 32'h0000_0000;
      cres_q <= (cmd.res == msq_pkg::P_VAL && cmd.exp != msq_pkg::P_OMIT) ?
                pres_q : 32'h0000_0000;
      conf_valid_q <= 1'b1;
    end
  end

  // Last used function for fetches without a name
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_fn_q <= msq_pkg::FN_NONE;
    end else if (exec && cmd.fn != msq_pkg::FN_NONE) begin
      if (cmd.op == msq_pkg::OP_CONF || cmd.op == msq_pkg::OP_MEAS ||
          cmd.op == msq_pkg::OP_READ || cmd.op == msq_pkg::OP_FETCH) begin
        last_fn_q <= cmd.fn;
      end
    end
  end

  // Sequencer state machine and acquisition strobes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= msq_pkg::ST_IDLE;
      fin_q <= 1'b0;
      pend_fn_q <= msq_pkg::FN_NONE;
      acq_start <= 1'b0;
      acq_abort <= 1'b0;
      acq_sel <= '0;
    end else if (ce) begin
      acq_start <= 1'b0;
      acq_abort <= 1'b0;
      fin_q <= 1'b0;
      if (dev_clear) begin
        // Device clear cancels the hold-off and any measurement
        acq_abort <= (st_q != msq_pkg::ST_IDLE);
        st_q <= msq_pkg::ST_IDLE;
      end else begin
        case (st_q)
          msq_pkg::ST_IDLE, msq_pkg::ST_RUN: begin
            if (st_q == msq_pkg::ST_RUN && acq_done) begin
              st_q <= msq_pkg::ST_IDLE;
            end
            if (exec) begin
              case (cmd.op)
                msq_pkg::OP_MEAS, msq_pkg::OP_READ: begin
                  // Abort a running one, then start afresh and hold
                  acq_abort <= (st_q == msq_pkg::ST_RUN);
                  pend_fn_q <= (cmd.op == msq_pkg::OP_MEAS) ? cmd.fn : req_fn;
                  if (cmd.op == msq_pkg::OP_MEAS) begin
                    acq_sel <= '{fn: cmd.fn, ch: cmd_ch};
                  end
                  st_q <= msq_pkg::ST_RESTART;
                end
                msq_pkg::OP_INIT: begin
                  if (st_q == msq_pkg::ST_IDLE) begin
                    acq_start <= 1'b1;
                    st_q <= msq_pkg::ST_RUN;
                  end
                end
                msq_pkg::OP_FETCH: begin
                  // Fetch while running waits for completion; one taken in the acq_done cycle is dropped
                  if (st_q == msq_pkg::ST_RUN && !acq_done) begin
                    pend_fn_q <= req_fn;
                    st_q <= msq_pkg::ST_HOLD;
                  end
                end
                msq_pkg::OP_CONF: begin
                  acq_sel <= '{fn: cmd.fn, ch: cmd_ch};
                end
                default: begin
                end
              endcase
            end
          end
          msq_pkg::ST_RESTART: begin
            acq_start <= 1'b1;
            st_q <= msq_pkg::ST_HOLD;
          end
          msq_pkg::ST_HOLD: begin
            // Only completion releases the hold-off here
            if (acq_done) begin
              fin_q <= 1'b1;
              st_q <= msq_pkg::ST_IDLE;
            end
          end
          default: begin
            st_q <= msq_pkg::ST_IDLE;
          end
        endcase
      end
    end
  end

  // Stored acquisition, kept across fetches
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      data_valid_q <= 1'b0;
      data_fn_q <= msq_pkg::FN_NONE;
      data_q <= 32'h0000_0000;
    end else if (ce) begin
      if (acq_start) begin
        data_valid_q <= 1'b0;
      end else if (acq_done && (st_q == msq_pkg::ST_RUN || st_q == msq_pkg::ST_HOLD)) begin
        data_valid_q <= acq_ok;
        data_fn_q <= acq_sel.fn;
        data_q <= acq_value;
      end
    end
  end

  // Output queue of one reply; reading the result pops it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      res_q <= 32'h0000_0000;
      tag_q <= '0;
      qvalid_q <= 1'b0;
    end else if (ce) begin
      if (push) begin
        qvalid_q <= 1'b1;
        tag_q.fmt_real <= fmt_real_q;
        tag_q.digits <= digits_q;
        if (fetch_go) begin
          res_q <= fetch_ok ? data_q : `MSQ_NAN_WORD;
          tag_q.nan <= !fetch_ok;
          tag_q.empty <= 1'b0;
          tag_q.fn <= fetch_fn;
          tag_q.derived <= fetch_ok && (fetch_fn != data_fn_q);
        end else begin
          // Configuration query reply, empty before any configure
          res_q <= {24'h00_0000, cfg_q};
          tag_q.nan <= 1'b0;
          tag_q.empty <= !conf_valid_q;
          tag_q.fn <= cfg_q.fn;
          tag_q.derived <= 1'b0;
        end
      end else if (rd_fire && paddr == `MSQ_OFF_RES) begin
        qvalid_q <= 1'b0;
      end
    end
  end

  // Sticky status and error code; a new event beats a clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      warn_q <= 1'b0;
      err_q <= 1'b0;
      ovr_q <= 1'b0;
      err_code_q <= 16'h0000;
    end else if (ce) begin
      if (exec && cmd.extra) begin
        warn_q <= 1'b1;
      end else if (wr_fire && paddr == `MSQ_OFF_STAT && pwdata[`MSQ_ST_WARN]) begin
        warn_q <= 1'b0;
      end
      if (push && qvalid_q && !(rd_fire && paddr == `MSQ_OFF_RES)) begin
        ovr_q <= 1'b1;
      end else if (wr_fire && paddr == `MSQ_OFF_STAT && pwdata[`MSQ_ST_OVR]) begin
        ovr_q <= 1'b0;
      end
      if (fetch_go && !fetch_ok) begin
        err_q <= 1'b1;
        err_code_q <= `MSQ_ERR_STALE;
      end else if (exec && cmd.op == msq_pkg::OP_CONFQ && !conf_valid_q) begin
        err_q <= 1'b1;
        err_code_q <= `MSQ_ERR_NO_CONF;
      end else if (exec && cmd.op == msq_pkg::OP_INIT && st_q != msq_pkg::ST_IDLE) begin
        err_q <= 1'b1;
        err_code_q <= `MSQ_ERR_INIT_IGN;
      end else if (wr_fire && paddr == `MSQ_OFF_STAT && pwdata[`MSQ_ST_ERR]) begin
        err_q <= 1'b0;
      end
    end
  end

  // Bus outputs straight from flops
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;

endmodule : msq_sequencer

// >>> core/msq_map.svh
/*
  Register offsets, field positions, reset values and fixed codes of the
  measurement instruction sequencer.
  Assumes inclusion by bare name; holds definitions only.
*/
`ifndef MSQ_MAP_SVH
`define MSQ_MAP_SVH

// Register byte offsets on the APB
`define MSQ_OFF_CMD 8'h00
`define MSQ_OFF_PEXP 8'h04
`define MSQ_OFF_PRES 8'h08
`define MSQ_OFF_CTRL 8'h0C
`define MSQ_OFF_STAT 8'h10
`define MSQ_OFF_ERR 8'h14
`define MSQ_OFF_CONF 8'h18
`define MSQ_OFF_CEXP 8'h1C
`define MSQ_OFF_CRES 8'h20
`define MSQ_OFF_RES 8'h24
`define MSQ_OFF_TAG 8'h28

// Widths of packed words carried in registers
`define MSQ_CMD_W 14
`define MSQ_CFG_W 8
`define MSQ_TAG_W 11

// Control register fields
`define MSQ_CTRL_MATH 0
`define MSQ_CTRL_STATS 1
`define MSQ_CTRL_LIMIT 2
`define MSQ_CTRL_ATRIG 3
`define MSQ_CTRL_FMT 4
`define MSQ_CTRL_DIG_LSB 8
`define MSQ_CTRL_DIG_MSB 11
`define MSQ_DIG_RST 4'h4

// Status register fields; 4 to 6 are sticky, write one to clear
`define MSQ_ST_BUSY 0
`define MSQ_ST_RUN 1
`define MSQ_ST_DATA 2
`define MSQ_ST_QVALID 3
`define MSQ_ST_WARN 4
`define MSQ_ST_ERR 5
`define MSQ_ST_OVR 6
`define MSQ_ST_CONF 7

// Error codes, 16-bit two's complement
`define MSQ_ERR_STALE 16'hFF1A
`define MSQ_ERR_INIT_IGN 16'hFF2B
`define MSQ_ERR_NO_CONF 16'hFF38

// Not-a-number result word, single precision
`define MSQ_NAN_WORD 32'h7E951BBA

`endif

// >>> core/msq_pkg.sv
/*
  Types of the measurement instruction sequencer: commands, functions,
  channel lists, parameter presence, states and carrier structs.
  Assumes nothing of its surroundings.
*/
package msq_pkg;

  // Command opcodes
  typedef enum logic [2:0] {
    OP_NOP = 3'h0, OP_CONF = 3'h1, OP_MEAS = 3'h2, OP_READ = 3'h3,
    OP_INIT = 3'h4, OP_FETCH = 3'h5, OP_CONFQ = 3'h6, OP_RSV = 3'h7
  } msq_op_e;

  // Measurement functions; none means omitted
  typedef enum logic [2:0] {
    FN_NONE = 3'h0, FN_FREQ = 3'h1, FN_PER = 3'h2, FN_RATIO = 3'h3,
    FN_VMAX = 3'h4, FN_VMIN = 3'h5, FN_PTP = 3'h6, FN_RSV = 3'h7
  } msq_fn_e;

  // Channel list codes
  typedef enum logic [2:0] {
    CH_OMIT = 3'h0, CH_1 = 3'h1, CH_2 = 3'h2, CH_12 = 3'h3, CH_21 = 3'h4
  } msq_ch_e;

  // Presence of a numeric parameter
  typedef enum logic [1:0] {
    P_OMIT = 2'h0, P_DEF = 2'h1, P_VAL = 2'h2
  } msq_pres_e;

  // Sequencer states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00, ST_RUN = 2'b01, ST_HOLD = 2'b10, ST_RESTART = 2'b11
  } msq_st_e;

  // Command word, opcode in the low bits
  typedef struct packed {
    logic extra;
    msq_pres_e res;
    msq_pres_e exp;
    msq_ch_e ch;
    msq_fn_e fn;
    msq_op_e op;
  } msq_cmd_s;

  // Stored configuration as reported by the configuration query
  typedef struct packed {
    logic res_def;
    logic exp_def;
    msq_ch_e ch;
    msq_fn_e fn;
  } msq_cfg_s;

  // Tag of the queued reply
  typedef struct packed {
    logic derived;
    logic nan;
    logic empty;
    msq_fn_e fn;
    logic fmt_real;
    logic [3:0] digits;
  } msq_tag_s;

  // Request to the acquisition engine
  typedef struct packed {
    msq_fn_e fn;
    msq_ch_e ch;
  } msq_acq_s;

endpackage : msq_pkg

// >>> sim/msq_sequencer_props.sv
/*
  Port checker of the sequencer.
  Assumes ce high, dev_clear low.
*/
`timescale 1ns/1ns
module msq_sequencer_props (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB side
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  // Acquisition and settings
  input wire logic acq_start,
  input wire logic acq_abort,
  input wire logic acq_done,
  input wire logic math_en,
  input wire logic stats_en,
  input wire logic limit_en,
  input wire logic atrig_en,
  input wire logic atrig_level_set,
  input wire logic atrig_run
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic tk; // Command word taken
  logic cm; // Configure or measure taken
  logic ta; // Command that must auto-trigger
  logic pend; // Acquisition hold-off pending
  logic [2:0] op, fn, ch;
  assign tk = psel && penable && pready && pwrite && (paddr == 8'h00);
  assign op = pwdata[2:0];
  assign fn = pwdata[5:3];
  assign ch = pwdata[8:6];
  assign cm = tk && (op == 3'h1 || op == 3'h2);
  assign ta = cm && (fn inside {3'h1, 3'h2, 3'h3}) && (ch != 3'h2);
  // Hold-off from measure or read to done
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend <= 1'b0;
    end else if (tk && (op == 3'h2 || op == 3'h3)) begin
      pend <= 1'b1;
    end else if (acq_done) begin
      pend <= 1'b0;
    end
  end
  // Enable and level, run next cycle
  sequence s_trig;
    atrig_en && atrig_level_set ##1 atrig_run;
  endsequence
  a_conf_off_ctl: assert property (cm |=> !math_en && !stats_en && !limit_en)
    else $error("settings left on");
  a_conf_no_start: assert property (tk && op == 3'h1 |=> !acq_start [*4])
    else $error("configure started");
  a_meas_start: assert property (tk && op == 3'h2 |-> ##[1:3] acq_start)
    else $error("measure did not start");
  a_read_start: assert property (tk && op == 3'h3 |-> ##[1:3] acq_start)
    else $error("read did not start");
  a_atrig_seq: assert property (ta |=> s_trig)
    else $error("auto-trigger steps missing");
  a_no_atrig_pk: assert property (cm && fn inside {3'h4, 3'h5, 3'h6}
    |=> !atrig_level_set ##1 !atrig_run)
    else $error("auto-trigger on peaks");
  a_run_cause: assert property ($rose(atrig_run) |-> $past(atrig_level_set))
    else $error("run without level");
  a_abort_restart: assert property (acq_abort |-> ##[0:1] acq_start)
    else $error("abort without restart");
  a_hold_cmds: assert property (pend |-> !tk)
    else $error("taken in hold-off");
endmodule : msq_sequencer_props
bind msq_sequencer msq_sequencer_props u_props (.*);

// >>> sim/msq_acq_model.sv
/*
  Acquisition model: one done per start; abort drops it.
  Assumes one-cycle pulses.
*/
`timescale 1ns/1ns
module msq_acq_model (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Requests and pace
  input wire logic acq_start,
  input wire logic acq_abort,
  input wire msq_pkg::msq_acq_s acq_sel,
  input wire logic slow,
  // Answers
  output logic acq_done,
  output logic acq_ok,
  output logic [31:0] acq_value
);
  int cnt; // Cycles left, 0 when idle
  int n_start; // Starts seen
  int n_abort; // Aborts seen
  // Count down; data lines toggle whenever no result is offered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 0;
      n_start <= 0;
      n_abort <= 0;
      acq_done <= 1'b0;
      acq_ok <= 1'b0;
      acq_value <= 32'h0;
    end else begin
      acq_done <= (cnt == 1);
      acq_ok <= (cnt == 1);
      acq_value <= (cnt == 1) ? {26'h1680000, acq_sel} : ~acq_value;
      n_start <= n_start + int'(acq_start);
      n_abort <= n_abort + int'(acq_abort);
      if (acq_abort) begin
        cnt <= 0;
      end else if (acq_start) begin
        cnt <= slow ? 40 : 3;
      end else if (cnt != 0) begin
        cnt <= cnt - 1;
      end
    end
  end
endmodule : msq_acq_model

// >>> sim/msq_sequencer_tb.sv
/*
  Sequencer bench over APB.
  Assumes the model's 5A000000 plus fn/ch result.
*/
`timescale 1ns/1ns
`include "msq_map.svh"
module msq_sequencer_tb;
  logic pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, slow;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rdat, acq_value;
  logic acq_start, acq_abort, acq_done, acq_ok, math_en, stats_en, limit_en;
  logic atrig_en, atrig_level_set, atrig_run, serr;
  msq_pkg::msq_acq_s acq_sel;
  int n_fail, checked, cyc, t0;
  msq_sequencer dut (.*, .dev_clear(1'b0));
  msq_acq_model u_acq (.*);
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  // Hang guard
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      complete_run();
    end
  end
  task automatic complete_run();
    $display("checked=%0d n_fail=%0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : complete_run
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      n_fail++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk
  // APB transfer held to pready at a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdat = prdata;
    serr = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb
  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rdat & m, e);
  endtask : rd
  // Command word; expected value as default
  task automatic cmd(input logic [2:0] o, input logic [2:0] f, input logic [2:0] c,
      input logic x);
    apb(1'b1, `MSQ_OFF_CMD, {18'h0, x, 4'h1, c, f, o});
  endtask : cmd
  // Wait until a reply is queued
  task automatic wq();
    do apb(1'b0, `MSQ_OFF_STAT, 32'h0); while (rdat[3] !== 1'b1);
  endtask : wq
  task automatic t_power();
    rd(`MSQ_OFF_CTRL, 32'hFFF, 32'h400);
    rd(8'h30, 32'h0, 32'h0);
    chk({31'h0, serr}, 32'h1);
    cmd(3'h6, 3'h0, 3'h0, 1'b0);
    wq();
    rd(`MSQ_OFF_TAG, 32'h100, 32'h100);
    rd(`MSQ_OFF_ERR, 32'hFFFF, {16'h0, `MSQ_ERR_NO_CONF});
    rd(`MSQ_OFF_RES, 32'h0, 32'h0);
    cmd(3'h5, 3'h0, 3'h0, 1'b0);
    wq();
    rd(`MSQ_OFF_RES, 32'hFFFFFFFF, `MSQ_NAN_WORD);
    rd(`MSQ_OFF_ERR, 32'hFFFF, {16'h0, `MSQ_ERR_STALE});
    $display("t_power done");
  endtask : t_power
  task automatic t_meas();
    apb(1'b1, `MSQ_OFF_CTRL, 32'h407);
    cmd(3'h2, 3'h1, 3'h1, 1'b0);
    wq();
    rd(`MSQ_OFF_RES, 32'hFFFFFFFF, 32'h5A000009);
    rd(`MSQ_OFF_CTRL, 32'hF, 32'h8);
    cmd(3'h6, 3'h0, 3'h0, 1'b0);
    wq();
    rd(`MSQ_OFF_RES, 32'h7, 32'h1);
    $display("t_meas done");
  endtask : t_meas
  task automatic t_fetch();
    cmd(3'h5, 3'h3, 3'h0, 1'b0);
    wq();
    rd(`MSQ_OFF_RES, 32'hFFFFFFFF, `MSQ_NAN_WORD);
    cmd(3'h5, 3'h2, 3'h0, 1'b0);
    wq();
    rd(`MSQ_OFF_TAG, 32'h4E0, 32'h440);
    rd(`MSQ_OFF_RES, 32'hFFFFFFFF, 32'h5A000009);
    cmd(3'h5, 3'h0, 3'h0, 1'b0);
    wq();
    rd(`MSQ_OFF_TAG, 32'hE0, 32'h40);
    rd(`MSQ_OFF_RES, 32'hFFFFFFFF, 32'h5A000009);
    $display("t_fetch done");
  endtask : t_fetch
  task automatic t_abort();
    slow <= 1'b1;
    cmd(3'h4, 3'h0, 3'h0, 1'b0);
    cmd(3'h3, 3'h0, 3'h0, 1'b0);
    t0 = cyc;
    cmd(3'h0, 3'h0, 3'h0, 1'b0);
    chk({31'h0, (cyc - t0) > 20}, 32'h1);
    wq();
    rd(`MSQ_OFF_RES, 32'hFFFFFFFF, 32'h5A000009);
    chk(u_acq.n_abort, 32'h1);
    cmd(3'h4, 3'h0, 3'h0, 1'b0);
    cmd(3'h2, 3'h1, 3'h1, 1'b0);
    wq();
    rd(`MSQ_OFF_RES, 32'hFFFFFFFF, 32'h5A000009);
    chk(u_acq.n_abort, 32'h2);
    slow <= 1'b0;
    $display("t_abort done");
  endtask : t_abort
  task automatic t_fmt();
    apb(1'b1, `MSQ_OFF_CTRL, 32'h10);
    cmd(3'h5, 3'h0, 3'h0, 1'b0);
    wq();
    rd(`MSQ_OFF_TAG, 32'h1F, 32'h11);
    rd(`MSQ_OFF_RES, 32'h0, 32'h0);
    apb(1'b1, `MSQ_OFF_CTRL, 32'hF00);
    cmd(3'h5, 3'h0, 3'h0, 1'b0);
    wq();
    rd(`MSQ_OFF_TAG, 32'h1F, 32'hF);
    rd(`MSQ_OFF_RES, 32'h0, 32'h0);
    $display("t_fmt done");
  endtask : t_fmt
  task automatic t_warn();
    cmd(3'h1, 3'h4, 3'h1, 1'b1);
    rd(`MSQ_OFF_STAT, 32'h10, 32'h10);
    rd(`MSQ_OFF_CONF, 32'h7, 32'h4);
    chk(u_acq.n_start, 32'h5);
    apb(1'b1, `MSQ_OFF_STAT, 32'h10);
    rd(`MSQ_OFF_STAT, 32'h10, 32'h0);
    $display("t_warn done");
  endtask : t_warn
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, slow, n_fail, checked, cyc} = '0;
    ce = 1'b1;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_power();
    t_meas();
    t_fetch();
    t_abort();
    t_fmt();
    t_warn();
    complete_run();
  end
endmodule : msq_sequencer_tb
